// *** hw/sdm_defines.svh ***
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH
// Overview of operation
// - With auto-read on, reading the receive data register clears rx full and tx empty.
// - Clearing tx empty moves the transmit data register into the shifter and starts a byte.
// - Exactly three transfer modes exist: full duplex, half duplex and dual.
// - Full duplex (select 00b) shifts out on the out line and in on the in line together.
// - After a full-duplex byte the receive shifter holds whatever was sampled.
// - Select 01b gives half duplex, sending and receiving in turn on the out line.
// - In half duplex and dual the out line is driven only while bidir enable is set.
// - Dual mode with bidir enable set sends and receives on the out line; with it clear it receives on both lines at twice the rate.
// - Dual receive takes even bits from the out line and odd bits from the in line.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SDM_OFF_CTRL      4'h0
`define SDM_OFF_STATUS    4'h4
`define SDM_OFF_TX_DATA   4'h8
`define SDM_OFF_RX_DATA   4'hC

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SDM_CTRL_SEL_LO   0
`define SDM_CTRL_SEL_HI   1
`define SDM_CTRL_BIDIR    2
`define SDM_CTRL_AUTO     3
`define SDM_CTRL_SELECT   4

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SDM_STAT_TXE      0
`define SDM_STAT_RXF      1
`define SDM_STAT_BUSY     2

// ----------------------------------------------------------------
// Select encodings and reset values
// ----------------------------------------------------------------
`define SDM_SEL_FULL      2'h0
`define SDM_SEL_HALF      2'h1
`define SDM_SEL_DUAL      2'h2
`define SDM_RST_CTRL      5'h00
`define SDM_RST_DATA      8'h00
`define SDM_BITS_SINGLE   3'h7
`define SDM_BITS_DUAL     3'h3
`endif

// *** hw/sdm_pkg.sv ***
package sdm_pkg;
    // Transfer mode taken from the input path select field
    typedef enum logic [1:0] {
        SDM_FULL,
        SDM_HALF,
        SDM_DUAL
    } sdm_mode_t;
endpackage

// *** hw/sdm_sync.sv ***
`timescale 1ns/10ps
module sdm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // Two flip-flop synchroniser; only the second stage is visible
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// *** hw/sdm_spi_master.sv ***
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "sdm_defines.svh"
module sdm_spi_master #(
    parameter int ADDR_W = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              link_clk,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   tx_buffer_empty_flag,
    output logic                   rx_buffer_full_flag,
    output logic                   spi_sclk,
    output logic                   spi_select_n,
    output logic                   serial_out_line_o,
    output logic                   serial_out_line_oe_n,
    input  wire logic              serial_out_line_i,
    input  wire logic              serial_in_line
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 4) begin : g_bad_addr
        $error("sdm_spi_master: ADDR_W must be at least 4");
    end

    // ----------------------------------------------------------------
    // Register side state (ref_clk)
    // ----------------------------------------------------------------
    logic [1:0]        input_path_select_q;
    logic              bidir_output_enable_q;
    logic              auto_read_q;
    logic              select_q;
    logic [7:0]        transmit_data_register_q;
    logic [7:0]        receive_data_register_q;
    logic [7:0]        receive_data_register_d;
    logic              txe_q;
    logic              txe_d;
    logic              rxf_q;
    logic              rxf_d;
    logic              busy_q;
    logic              start_tgl_q;
    logic              done_prev_q;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    sdm_pkg::sdm_mode_t frame_mode_q;
    sdm_pkg::sdm_mode_t sel_mode;
    logic              frame_bidir_q;

    // ----------------------------------------------------------------
    // Link side state (link_clk)
    // ----------------------------------------------------------------
    logic              start_sync;
    logic              start_prev_q;
    logic              active_q;
    logic              phase_q;
    logic [2:0]        count_q;
    logic [7:0]        tx_shift_q;
    logic [7:0]        rx_shift_q;
    logic              sclk_q;
    logic              sdo_q;
    logic              done_tgl_q;
    logic              done_sync;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire hit_ctrl   = (reg_addr == ADDR_W'(`SDM_OFF_CTRL));
    wire hit_status = (reg_addr == ADDR_W'(`SDM_OFF_STATUS));
    wire hit_tx     = (reg_addr == ADDR_W'(`SDM_OFF_TX_DATA));
    wire hit_rx     = (reg_addr == ADDR_W'(`SDM_OFF_RX_DATA));
    wire wr_ctrl    = reg_wr & hit_ctrl;
    wire wr_tx      = reg_wr & hit_tx;
    wire rd_rx      = reg_rd & hit_rx;

    // ----------------------------------------------------------------
    // Transfer start and completion events
    // ----------------------------------------------------------------
    // Auto-read turns the receive read into a tx empty clear
    wire auto_kick  = rd_rx & auto_read_q;
    // A transmit write or an auto-read clear starts the next byte, but only while no byte is busy
    wire kick       = wr_tx | auto_kick;
    wire start      = kick & ~busy_q;
    wire done_pulse = done_sync ^ done_prev_q;

    // Select field decode; the spare code falls back to full duplex
    assign sel_mode = (input_path_select_q == `SDM_SEL_HALF) ? sdm_pkg::SDM_HALF :
                      (input_path_select_q == `SDM_SEL_DUAL) ? sdm_pkg::SDM_DUAL :
                      sdm_pkg::SDM_FULL;

    // ----------------------------------------------------------------
    // Flag and data next values
    // ----------------------------------------------------------------
    // Completion sets both flags and wins over a clear in the same cycle
    always_comb begin
        txe_d = txe_q;
        if (done_pulse) begin
            txe_d = 1'b1;
        end else if (start) begin
            txe_d = 1'b0;
        end
    end

    always_comb begin
        rxf_d = rxf_q;
        if (done_pulse) begin
            rxf_d = 1'b1;
        end else if (rd_rx) begin
            rxf_d = 1'b0;
        end
    end

    // Received byte is stable in the link shifter once done is seen
    assign receive_data_register_d = done_pulse ? rx_shift_q : receive_data_register_q;

    // Read data mux; unmapped addresses read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d[`SDM_CTRL_SEL_HI:`SDM_CTRL_SEL_LO] = input_path_select_q;
            rdata_d[`SDM_CTRL_BIDIR]  = bidir_output_enable_q;
            rdata_d[`SDM_CTRL_AUTO]   = auto_read_q;
            rdata_d[`SDM_CTRL_SELECT] = select_q;
        end else if (hit_status) begin
            rdata_d[`SDM_STAT_TXE]  = txe_q;
            rdata_d[`SDM_STAT_RXF]  = rxf_q;
            rdata_d[`SDM_STAT_BUSY] = busy_q;
        end else if (hit_tx) begin
            rdata_d[7:0] = transmit_data_register_q;
        end else if (hit_rx) begin
            rdata_d[7:0] = receive_data_register_q;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            input_path_select_q   <= 2'(`SDM_RST_CTRL);
            bidir_output_enable_q <= 1'b0;
            auto_read_q           <= 1'b0;
            select_q              <= 1'b0;
        end else if (wr_ctrl) begin
            input_path_select_q   <= reg_wdata[`SDM_CTRL_SEL_HI:`SDM_CTRL_SEL_LO];
            bidir_output_enable_q <= reg_wdata[`SDM_CTRL_BIDIR];
            auto_read_q           <= reg_wdata[`SDM_CTRL_AUTO];
            select_q              <= reg_wdata[`SDM_CTRL_SELECT];
        end
    end

    // Transmit data held stable while a byte is in flight
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            transmit_data_register_q <= `SDM_RST_DATA;
        end else if (wr_tx && !busy_q) begin
            transmit_data_register_q <= reg_wdata[7:0];
        end
    end

    // Flags, received byte and read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txe_q                   <= 1'b1;
            rxf_q                   <= 1'b0;
            receive_data_register_q <= `SDM_RST_DATA;
            rdata_q                 <= 32'h0000_0000;
            done_prev_q             <= 1'b0;
        end else begin
            txe_q                   <= txe_d;
            rxf_q                   <= rxf_d;
            receive_data_register_q <= receive_data_register_d;
            rdata_q                 <= reg_rd ? rdata_d : 32'h0000_0000;
            done_prev_q             <= done_sync;
        end
    end

    // Frame snapshot and start toggle toward the link side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_q        <= 1'b0;
            start_tgl_q   <= 1'b0;
            frame_mode_q  <= sdm_pkg::SDM_FULL;
            frame_bidir_q <= 1'b0;
        end else if (start) begin
            busy_q        <= 1'b1;
            start_tgl_q   <= ~start_tgl_q;
            frame_mode_q  <= sel_mode;
            frame_bidir_q <= bidir_output_enable_q;
        end else if (done_pulse) begin
            busy_q        <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Domain crossings
    // ----------------------------------------------------------------
    sdm_sync #(
        .W (1)
    ) u_start_sync (
        .clk  (link_clk),
        .rst  (rst),
        .din  (start_tgl_q),
        .dout (start_sync)
    );

    sdm_sync #(
        .W (1)
    ) u_done_sync (
        .clk  (ref_clk),
        .rst  (rst),
        .din  (done_tgl_q),
        .dout (done_sync)
    );

    // ----------------------------------------------------------------
    // Link shifter (link_clk)
    // ----------------------------------------------------------------
    // Snapshot fields stay fixed from start toggle until done toggle
    wire dual_rx  = (frame_mode_q == sdm_pkg::SDM_DUAL) & ~frame_bidir_q;
    wire last_cnt = (count_q == (dual_rx ? `SDM_BITS_DUAL : `SDM_BITS_SINGLE));
    wire start_l  = start_sync ^ start_prev_q;

    // Sample point data per mode
    logic [7:0] rx_next;
    always_comb begin
        rx_next = rx_shift_q;
        unique case (frame_mode_q)
            sdm_pkg::SDM_FULL: begin
                rx_next = {rx_shift_q[6:0], serial_in_line};
            end
            sdm_pkg::SDM_HALF: begin
                rx_next = {rx_shift_q[6:0], serial_out_line_i};
            end
            sdm_pkg::SDM_DUAL: begin
                if (frame_bidir_q) begin
                    rx_next = {rx_shift_q[6:0], serial_out_line_i};
                end else begin
                    rx_next = {rx_shift_q[5:0], serial_in_line, serial_out_line_i};
                end
            end
        endcase
    end

    // Start edge tracking
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_sync;
        end
    end

    // Phase 0 drives data with clock low, phase 1 raises clock and samples
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            active_q   <= 1'b0;
            phase_q    <= 1'b0;
            count_q    <= 3'h0;
            tx_shift_q <= 8'h00;
            rx_shift_q <= 8'h00;
            sclk_q     <= 1'b0;
            sdo_q      <= 1'b0;
            done_tgl_q <= 1'b0;
        end else if (start_l && !active_q) begin
            active_q   <= 1'b1;
            phase_q    <= 1'b0;
            count_q    <= 3'h0;
            tx_shift_q <= {transmit_data_register_q[6:0], 1'b0};
            sdo_q      <= transmit_data_register_q[7];
            sclk_q     <= 1'b0;
        end else if (active_q && !phase_q) begin
            phase_q    <= 1'b1;
            sclk_q     <= 1'b1;
            rx_shift_q <= rx_next;
        end else if (active_q) begin
            phase_q    <= 1'b0;
            sclk_q     <= 1'b0;
            if (last_cnt) begin
                active_q   <= 1'b0;
                done_tgl_q <= ~done_tgl_q;
            end else begin
                count_q    <= count_q + 3'h1;
                sdo_q      <= tx_shift_q[7];
                tx_shift_q <= {tx_shift_q[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Full duplex always drives; other modes follow bidir enable
    wire drive_out = (sel_mode == sdm_pkg::SDM_FULL) | bidir_output_enable_q;

    assign serial_out_line_oe_n = ~drive_out;
    assign serial_out_line_o    = sdo_q;
    assign spi_sclk             = sclk_q;
    assign spi_select_n         = ~select_q;
    assign reg_rdata            = rdata_q;
    assign tx_buffer_empty_flag = txe_q;
    assign rx_buffer_full_flag  = rxf_q;

endmodule

// *** verif/sdm_spi_master_checker.sv ***
`timescale 1ns/10ps
`include "sdm_defines.svh"
module sdm_spi_master_checker #(
    parameter int ADDR_W = 4
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              link_clk,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              tx_buffer_empty_flag,
    input wire logic              rx_buffer_full_flag,
    input wire logic              spi_sclk,
    input wire logic              spi_select_n,
    input wire logic              serial_out_line_o,
    input wire logic              serial_out_line_oe_n,
    input wire logic              serial_out_line_i,
    input wire logic              serial_in_line
);
    // --------------------
    // Shadow of control
    // --------------------
    logic [4:0] ctrl_q;
    logic       sclk_p;
    logic [3:0] nclk_q;
    wire        wr_tx  = reg_wr && reg_addr == `SDM_OFF_TX_DATA;
    wire        rd_rx  = reg_rd && reg_addr == `SDM_OFF_RX_DATA;
    wire [1:0]  sel    = ctrl_q[1:0];
    wire        dualrx = sel == `SDM_SEL_DUAL && !ctrl_q[2];

    // Control as written by software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) ctrl_q <= `SDM_RST_CTRL;
        else if (reg_wr && reg_addr == `SDM_OFF_CTRL) ctrl_q <= reg_wdata[4:0];
    end

    // Counts serial clock rises per byte; two low samples mark the gap
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sclk_p <= 1'b0;
            nclk_q <= 4'h0;
        end else begin
            sclk_p <= spi_sclk;
            if (spi_sclk && !sclk_p) nclk_q <= nclk_q + 4'h1;
            else if (!spi_sclk && !sclk_p) nclk_q <= 4'h0;
        end
    end

    // --------------------
    // Properties
    // --------------------
    AST_FULL_DRIVE: assert property (@(posedge ref_clk) disable iff (rst)
        (sel == `SDM_SEL_FULL || sel == 2'h3) |-> !serial_out_line_oe_n)
        else $error("out line released in full duplex");
    AST_HALF_DIR: assert property (@(posedge ref_clk) disable iff (rst)
        sel == `SDM_SEL_HALF |-> serial_out_line_oe_n == !ctrl_q[2])
        else $error("half duplex direction wrong");
    AST_DUAL_DIR: assert property (@(posedge ref_clk) disable iff (rst)
        sel == `SDM_SEL_DUAL |-> serial_out_line_oe_n == !ctrl_q[2])
        else $error("dual direction wrong");
    AST_TX_START: assert property (@(posedge ref_clk) disable iff (rst)
        wr_tx && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
        else $error("transmit write did not start");
    AST_AUTO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        rd_rx && ctrl_q[3] && rx_buffer_full_flag && tx_buffer_empty_flag
        |=> !rx_buffer_full_flag && !tx_buffer_empty_flag)
        else $error("auto read did not clear both flags");
    AST_DONE_FLAGS: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(rx_buffer_full_flag) |-> tx_buffer_empty_flag)
        else $error("byte done without transmit empty");
    AST_BYTE_LEN: assert property (@(posedge link_clk) disable iff (rst)
        !spi_sclk && !sclk_p && nclk_q != 4'h0 |-> nclk_q == (dualrx ? 4'h4 : 4'h8))
        else $error("wrong number of serial clocks");
    AST_SDO_STABLE: assert property (@(posedge link_clk) disable iff (rst)
        $rose(spi_sclk) && !serial_out_line_oe_n |-> $stable(serial_out_line_o))
        else $error("out line changed at sampling edge");

    // Main scenarios
    COV_BYTE: cover property (@(posedge ref_clk) disable iff (rst) $rose(rx_buffer_full_flag));
    COV_DUAL: cover property (@(posedge ref_clk) disable iff (rst) dualrx && rd_rx);
    COV_AUTO: cover property (@(posedge ref_clk) disable iff (rst) rd_rx && ctrl_q[3]);
endmodule

bind sdm_spi_master sdm_spi_master_checker #(.ADDR_W(ADDR_W)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .rx_buffer_full_flag(rx_buffer_full_flag),
    .spi_sclk(spi_sclk), .spi_select_n(spi_select_n), .serial_out_line_o(serial_out_line_o),
    .serial_out_line_oe_n(serial_out_line_oe_n), .serial_out_line_i(serial_out_line_i),
    .serial_in_line(serial_in_line));

// *** verif/sdm_slave_model.sv ***
`timescale 1ns/10ps
module sdm_slave_model (
    input  wire logic       spi_sclk,
    input  wire logic       spi_select_n,
    input  wire logic       restart,
    input  wire logic       dual,
    input  wire logic       half,
    input  wire logic [7:0] reply,
    input  wire logic       line_out,
    output logic            drv_out,
    output logic            drv_in,
    output logic      [7:0] cap_q
);
    logic [2:0] cnt_q;
    wire  [2:0] i_one = ~cnt_q;
    wire  [1:0] i_pr  = ~cnt_q[1:0];
    wire        b_out = dual ? reply[{i_pr, 1'b0}] : reply[i_one];
    wire        b_in  = dual ? reply[{i_pr, 1'b1}] : (half ^ reply[i_one]);

    // Unselected, the lines show the inverse of the bit, never a stale copy
    assign drv_out = b_out ^ spi_select_n;
    assign drv_in  = b_in ^ spi_select_n;

    // Next bit is presented after each falling serial clock, MSB first
    always_ff @(negedge spi_sclk or posedge restart) begin
        if (restart) cnt_q <= 3'h0;
        else cnt_q <= cnt_q + 3'h1;
    end

    // Captures what the master sends on the out line
    always_ff @(posedge spi_sclk) begin
        cap_q <= {cap_q[6:0], line_out};
    end
endmodule

// *** verif/spi_master_duplex_dual_modes_test.sv ***
`timescale 1ns/10ps
`include "sdm_defines.svh"
module spi_master_duplex_dual_modes_test;
    logic        ref_clk;
    logic        link_clk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        txe;
    logic        rxf;
    logic        sclk;
    logic        sel_n;
    logic        sdo_o;
    logic        oe_n;
    logic        drv_out;
    logic        drv_in;
    logic        restart;
    logic [7:0]  reply;
    logic [7:0]  cap;
    logic [4:0]  ctl;
    logic [31:0] rdv;
    int          error_cnt;
    int          n_compared;
    int          cyc;
    wire         line_out = oe_n ? drv_out : sdo_o;

    sdm_spi_master #(.ADDR_W(4)) dut (
        .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_buffer_empty_flag(txe), .rx_buffer_full_flag(rxf), .spi_sclk(sclk),
        .spi_select_n(sel_n), .serial_out_line_o(sdo_o), .serial_out_line_oe_n(oe_n),
        .serial_out_line_i(line_out), .serial_in_line(drv_in));
    sdm_slave_model slv (
        .spi_sclk(sclk), .spi_select_n(sel_n), .restart(restart),
        .dual(ctl[1:0] == `SDM_SEL_DUAL), .half(ctl[1:0] == `SDM_SEL_HALF),
        .reply(reply), .line_out(line_out), .drv_out(drv_out), .drv_in(drv_in),
        .cap_q(cap));

    // --------------------
    // Clocks and watchdog
    // --------------------
    always #25 ref_clk = ~ref_clk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    // --------------------
    // Shared tasks
    // --------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task wait_rxf();
        for (int i = 0; i < 400 && rxf !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("rx_full", rxf, 1'b1);
    endtask
    // Sets mode and slave answer, then sends one byte
    task xfer(input logic [4:0] c, input logic [7:0] tx, input logic [7:0] rep);
        ctl   = c;
        reply = rep;
        wr(`SDM_OFF_CTRL, {27'h0, c});
        restart = 1'b1;
        #1 restart = 1'b0;
        wr(`SDM_OFF_TX_DATA, {24'h0, tx});
        wait_rxf();
    endtask
    task summarize();
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task t_reset();
        chk("tx_empty", txe, 1'b1);
        chk("rx_full", rxf, 1'b0);
        chk("select_n", sel_n, 1'b1);
        chk("oe_n", oe_n, 1'b0);
        rd(`SDM_OFF_CTRL, rdv);
        chk("ctrl", rdv, 32'h0);
        rd(`SDM_OFF_STATUS, rdv);
        chk("status", rdv, 32'h1);
        rd(4'h2, rdv);
        chk("unmapped", rdv, 32'h0);
    endtask
    task t_full();
        xfer(5'h10, 8'h3C, 8'hA5);
        chk("slave_cap", cap, 8'h3C);
        rd(`SDM_OFF_RX_DATA, rdv);
        chk("rx_full", rdv, 8'hA5);
        chk("rx_flag", rxf, 1'b0);
    endtask
    task t_half();
        xfer(5'h15, 8'h96, 8'h00);
        chk("oe_n", oe_n, 1'b0);
        chk("slave_cap", cap, 8'h96);
        rd(`SDM_OFF_RX_DATA, rdv);
        xfer(5'h11, 8'hFF, 8'h5A);
        chk("oe_n", oe_n, 1'b1);
        rd(`SDM_OFF_RX_DATA, rdv);
        chk("rx_half", rdv, 8'h5A);
    endtask
    task t_dual();
        xfer(5'h16, 8'hC3, 8'h00);
        chk("slave_cap", cap, 8'hC3);
        rd(`SDM_OFF_RX_DATA, rdv);
        xfer(5'h12, 8'hFF, 8'h6D);
        chk("oe_n", oe_n, 1'b1);
        rd(`SDM_OFF_RX_DATA, rdv);
        chk("rx_dual", rdv, 8'h6D);
        ctl = 5'h13;
        wr(`SDM_OFF_CTRL, 32'h13);
        #1 chk("oe_n", oe_n, 1'b0);
    endtask
    // Auto-read chain of two bytes, then auto-read is switched off and a receive read starts no byte
    task t_auto();
        xfer(5'h18, 8'h11, 8'h42);
        rd(`SDM_OFF_RX_DATA, rdv);
        chk("rx_auto", rdv, 8'h42);
        chk("rx_flag", rxf, 1'b0);
        chk("tx_flag", txe, 1'b0);
        rd(`SDM_OFF_STATUS, rdv);
        chk("status", rdv, 32'h4);
        wr(`SDM_OFF_TX_DATA, 32'hEE);
        wait_rxf();
        chk("slave_cap", cap, 8'h11);
        rd(`SDM_OFF_TX_DATA, rdv);
        chk("tx_kept", rdv, 8'h11);
        wr(`SDM_OFF_CTRL, 32'h10);
        rd(`SDM_OFF_RX_DATA, rdv);
        chk("rx_auto", rdv, 8'h42);
        chk("tx_flag", txe, 1'b1);
    endtask

    initial begin
        ref_clk    = 1'b0;
        rst        = 1'b1;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        restart    = 1'b1;
        reply      = 8'h00;
        ctl        = 5'h00;
        error_cnt  = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (20) @(posedge ref_clk);
        rst     <= 1'b0;
        restart <= 1'b0;
        #1;
        t_reset();
        t_full();
        t_half();
        t_dual();
        t_auto();
        summarize();
    end
endmodule
